// ---- src/nfc_pkg.sv ----
// constants, codes and state types for the flash command sequencer host
package nfc_pkg;
  // flash command bytes
  localparam logic [7:0] CMD_READ1      = 8'h00;
  localparam logic [7:0] CMD_READ2      = 8'h30;
  localparam logic [7:0] CMD_COL_OUT    = 8'h05;
  localparam logic [7:0] CMD_CACHE      = 8'h31;
  localparam logic [7:0] CMD_CACHE_LAST = 8'h3F;
  localparam logic [7:0] CMD_DIN        = 8'h80;
  localparam logic [7:0] CMD_PROG       = 8'h10;
  localparam logic [7:0] CMD_CACHE_PROG = 8'h15;
  localparam logic [7:0] CMD_COPY_RD    = 8'h3A;
  localparam logic [7:0] CMD_COPY       = 8'h8C;
  localparam logic [7:0] CMD_ERASE      = 8'h60;
  localparam logic [7:0] CMD_ID         = 8'h90;
  localparam logic [7:0] CMD_STATUS     = 8'h70;
  localparam logic [7:0] CMD_RESET      = 8'hFF;

  // register word addresses
  localparam logic [2:0] REG_CTRL = 3'h0;
  localparam logic [2:0] REG_ADDR = 3'h1;
  localparam logic [2:0] REG_DATA = 3'h2;
  localparam logic [2:0] REG_STAT = 3'h3;
  localparam logic [2:0] REG_WP   = 3'h4;

  // control word fields
  localparam int CTRL_CMD1_LSB  = 0;
  localparam int CTRL_CMD2_LSB  = 8;
  localparam int CTRL_NADDR_LSB = 16;
  localparam int CTRL_HAS2_BIT  = 19;
  localparam int CTRL_WAIT_BIT  = 20;
  localparam int CTRL_FIRST_LSB = 21;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // status byte bits as the flash reports them
  localparam int SB_CUR_FAIL  = 0;
  localparam int SB_PREV_FAIL = 1;
  localparam int SB_PB_READY  = 5;
  localparam int SB_DC_READY  = 6;
  localparam int SB_UNPROT    = 7;

  // pin cycle kinds
  localparam logic [1:0] K_CMD  = 2'h0;
  localparam logic [1:0] K_ADDR = 2'h1;
  localparam logic [1:0] K_DIN  = 2'h2;
  localparam logic [1:0] K_DOUT = 2'h3;

  // timing
  localparam int CLK_NS      = 10;
  localparam int T_STROBE_NS = 25;
  localparam int T_WB_NS     = 100;
  localparam logic [1:0] STROBE_CYC =
    2'((T_STROBE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] WB_CYC = 4'((T_WB_NS + CLK_NS - 1) / CLK_NS);

  typedef enum logic [3:0] {
    PH_IDLE = 4'h1,
    PH_SET  = 4'h2,
    PH_LOW  = 4'h4,
    PH_HIGH = 4'h8
  } nfc_ph_e;

  typedef enum logic [8:0] {
    ST_IDLE   = 9'h001,
    ST_CMD1   = 9'h002,
    ST_ADDR   = 9'h004,
    ST_CMD2   = 9'h008,
    ST_WBUSY  = 9'h010,
    ST_WREADY = 9'h020,
    ST_DWR    = 9'h040,
    ST_DRD    = 9'h080,
    ST_ACK    = 9'h100
  } nfc_st_e;
endpackage : nfc_pkg

// ---- src/nfc_pin_cycle.sv ----
// one strobed byte cycle on the flash pins: command, address, data in/out
`timescale 1ns/1ps
`default_nettype none
module nfc_pin_cycle (
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  input  wire logic       go,
  input  wire logic [1:0] kind,
  input  wire logic [7:0] wbyte,
  input  wire logic [7:0] io_in,
  output logic            cle,
  output logic            ale,
  output logic            we_n,
  output logic            output_strobe_n,
  output logic [7:0]      io_out,
  output logic            io_oe,
  output logic [7:0]      rbyte,
  output logic            done
);
  typedef struct packed {
    nfc_pkg::nfc_ph_e ph;
    logic [1:0]       cnt;
    logic [1:0]       kind;
    logic             cle;
    logic             ale;
    logic             we_n;
    logic             re_n;
    logic [7:0]       io_out;
    logic             io_oe;
    logic [7:0]       rbyte;
    logic             done;
  } nfc_pc_s;

  nfc_pc_s s_r, s_nxt;

  // setup, strobe low, hold; each phase lasts the strobe count
  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    case (s_r.ph)
      nfc_pkg::PH_IDLE: begin
        if (go) begin
          s_nxt.kind   = kind;
          s_nxt.cle    = (kind == nfc_pkg::K_CMD);
          s_nxt.ale    = (kind == nfc_pkg::K_ADDR);
          s_nxt.io_oe  = (kind != nfc_pkg::K_DOUT);
          s_nxt.io_out = wbyte;
          s_nxt.cnt    = nfc_pkg::STROBE_CYC - 2'd1;
          s_nxt.ph     = nfc_pkg::PH_SET;
        end
      end
      nfc_pkg::PH_SET: begin
        if (s_r.cnt == 2'd0) begin
          if (s_r.kind == nfc_pkg::K_DOUT) begin
            s_nxt.re_n = 1'b0; // one falling edge per byte
          end else begin
            s_nxt.we_n = 1'b0;
          end
          s_nxt.cnt = nfc_pkg::STROBE_CYC - 2'd1;
          s_nxt.ph  = nfc_pkg::PH_LOW;
        end else begin
          s_nxt.cnt = s_r.cnt - 2'd1;
        end
      end
      nfc_pkg::PH_LOW: begin
        if (s_r.cnt == 2'd0) begin
          if (s_r.kind == nfc_pkg::K_DOUT) begin
            s_nxt.rbyte = io_in; // byte of this falling strobe
          end
          s_nxt.we_n = 1'b1;
          s_nxt.re_n = 1'b1;
          s_nxt.cnt  = nfc_pkg::STROBE_CYC - 2'd1;
          s_nxt.ph   = nfc_pkg::PH_HIGH;
        end else begin
          s_nxt.cnt = s_r.cnt - 2'd1;
        end
      end
      nfc_pkg::PH_HIGH: begin
        if (s_r.cnt == 2'd0) begin
          s_nxt.cle   = 1'b0;
          s_nxt.ale   = 1'b0;
          s_nxt.io_oe = 1'b0;
          s_nxt.done  = 1'b1;
          s_nxt.ph    = nfc_pkg::PH_IDLE;
        end else begin
          s_nxt.cnt = s_r.cnt - 2'd1;
        end
      end
      default: s_nxt.ph = nfc_pkg::PH_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s_r <= '{ph: nfc_pkg::PH_IDLE, we_n: 1'b1, re_n: 1'b1, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign cle             = s_r.cle;
  assign ale             = s_r.ale;
  assign we_n            = s_r.we_n;
  assign output_strobe_n = s_r.re_n;
  assign io_out          = s_r.io_out;
  assign io_oe           = s_r.io_oe;
  assign rbyte           = s_r.rbyte;
  assign done            = s_r.done;

  // read strobe low exactly three cycles, then high again
  property p_re_width;
    @(posedge sys_clk) disable iff (!resetn)
      $fell(s_r.re_n) |-> !s_r.re_n [*3] ##1 s_r.re_n;
  endproperty
  a_re_width: assert property (p_re_width)
    else $error("read strobe width wrong");

  // never both strobes low
  property p_one_strobe;
    @(posedge sys_clk) disable iff (!resetn)
      !(!s_r.we_n && !s_r.re_n);
  endproperty
  a_one_strobe: assert property (p_one_strobe)
    else $error("both strobes low");

  // latch enables exclusive and the bus driven while writing
  property p_latch_excl;
    @(posedge sys_clk) disable iff (!resetn)
      $fell(s_r.we_n) |-> !(s_r.cle && s_r.ale) && s_r.io_oe;
  endproperty
  a_latch_excl: assert property (p_latch_excl)
    else $error("bad latch enables on write strobe");
endmodule : nfc_pin_cycle
`default_nettype wire

// ---- src/nfc_host.sv ----
// host sequencer: Avalon-MM registers driving a byte-wide flash port
`timescale 1ns/1ps
`default_nettype none
module nfc_host (
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic [2:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic             ce_n,
  output logic             cle,
  output logic             ale,
  output logic             we_n,
  output logic             output_strobe_n,
  output logic             wp_n,
  output logic [7:0]       io_out,
  output logic             io_oe,
  input  wire logic [7:0]  io_in,
  input  wire logic        busy_indicator
);
  typedef struct packed {
    nfc_pkg::nfc_st_e st;
    logic             issued;
    logic             go;
    logic [1:0]       kind;
    logic [7:0]       wbyte;
    logic [31:0]      ctrl;
    logic [31:0]      addr;
    logic [1:0]       aidx;
    logic [2:0]       acnt;
    logic [3:0]       wcnt;
    logic             refused;
    logic             read_ok;
    logic             copy_ok;
    logic             wp_en;
    logic [7:0]       sbyte;
    logic [7:0]       id3;
    logic [1:0]       rd_mode;
    logic [2:0]       rd_idx;
    logic [31:0]      rdata;
    logic             wreq;
    logic             ce_n;
    logic             wp_n;
  } nfc_host_s;

  nfc_host_s s_r, s_nxt;
  logic [7:0] cmd1, cmd2, w_cmd1, e_rbyte;
  logic [2:0] naddr;
  logic       has2, wt, e_done, legal;
  logic [31:0] stat;

  // fields of the stored and incoming control words
  assign cmd1   = s_r.ctrl[nfc_pkg::CTRL_CMD1_LSB +: 8];
  assign cmd2   = s_r.ctrl[nfc_pkg::CTRL_CMD2_LSB +: 8];
  assign naddr  = s_r.ctrl[nfc_pkg::CTRL_NADDR_LSB +: 3];
  assign has2   = s_r.ctrl[nfc_pkg::CTRL_HAS2_BIT];
  assign wt     = s_r.ctrl[nfc_pkg::CTRL_WAIT_BIT];
  assign w_cmd1 = avs_writedata[nfc_pkg::CTRL_CMD1_LSB +: 8];

  // start checks: busy gate, cache read and copy ordering
  assign legal = (busy_indicator || w_cmd1 == nfc_pkg::CMD_STATUS ||
                  w_cmd1 == nfc_pkg::CMD_RESET) &&
                 !(w_cmd1 == nfc_pkg::CMD_CACHE && !s_r.read_ok) &&
                 !(w_cmd1 == nfc_pkg::CMD_COPY && !s_r.copy_ok);

  // status word with decoded pass/fail validity and id fields
  assign stat = {8'h00, s_r.sbyte, 2'b00, s_r.copy_ok, s_r.read_ok,
                 s_r.id3[3:2], s_r.id3[1:0],
                 !s_r.sbyte[nfc_pkg::SB_UNPROT],
                 s_r.sbyte[nfc_pkg::SB_DC_READY],
                 s_r.sbyte[nfc_pkg::SB_DC_READY] &
                   s_r.sbyte[nfc_pkg::SB_PREV_FAIL],
                 s_r.sbyte[nfc_pkg::SB_PB_READY],
                 s_r.sbyte[nfc_pkg::SB_PB_READY] &
                   s_r.sbyte[nfc_pkg::SB_CUR_FAIL],
                 s_r.refused, busy_indicator, 1'b0};

  // step after command or address bytes
  function automatic nfc_pkg::nfc_st_e after_bytes(
    input logic [2:0] na, input logic h2, input logic w, input logic adone);
    if (!adone && na != 3'd0) begin
      after_bytes = nfc_pkg::ST_ADDR;
    end else if (h2) begin
      after_bytes = nfc_pkg::ST_CMD2;
    end else if (w) begin
      after_bytes = nfc_pkg::ST_WBUSY;
    end else begin
      after_bytes = nfc_pkg::ST_ACK;
    end
  endfunction : after_bytes

  // sequencer and register slave
  always_comb begin
    s_nxt = s_r;
    s_nxt.go = 1'b0;
    s_nxt.ce_n = 1'b0;
    case (s_r.st)
      nfc_pkg::ST_IDLE: begin
        if (avs_write || avs_read) begin
          s_nxt.st = nfc_pkg::ST_ACK;
          s_nxt.rdata = 32'h0000_0000;
          case (avs_address)
            nfc_pkg::REG_CTRL: begin
              if (avs_read) begin
                s_nxt.rdata = s_r.ctrl;
              end else if (legal) begin
                s_nxt.ctrl = avs_writedata;
                s_nxt.refused = 1'b0;
                s_nxt.wcnt = nfc_pkg::WB_CYC;
                s_nxt.st = nfc_pkg::ST_CMD1;
              end else begin
                s_nxt.refused = 1'b1;
              end
            end
            nfc_pkg::REG_ADDR: begin
              if (avs_write) s_nxt.addr = avs_writedata;
              s_nxt.rdata = s_r.addr;
            end
            nfc_pkg::REG_DATA: begin
              s_nxt.kind = avs_write ? nfc_pkg::K_DIN : nfc_pkg::K_DOUT;
              s_nxt.wbyte = avs_writedata[7:0];
              s_nxt.st = avs_write ? nfc_pkg::ST_DWR : nfc_pkg::ST_DRD;
            end
            nfc_pkg::REG_STAT: s_nxt.rdata = stat;
            nfc_pkg::REG_WP: begin
              if (avs_write) s_nxt.wp_en = avs_writedata[0];
              s_nxt.rdata = {31'h0000_0000, s_r.wp_en};
            end
            default: s_nxt.rdata = 32'h0000_0000;
          endcase
        end
      end
      nfc_pkg::ST_CMD1: begin
        if (!s_r.issued) begin
          s_nxt.issued = 1'b1;
          s_nxt.go = 1'b1;
          s_nxt.kind = nfc_pkg::K_CMD;
          s_nxt.wbyte = cmd1;
        end else if (e_done) begin
          s_nxt.issued = 1'b0;
          s_nxt.rd_idx = 3'd0;
          s_nxt.rd_mode = (cmd1 == nfc_pkg::CMD_STATUS) ? 2'd1 :
                          (cmd1 == nfc_pkg::CMD_ID) ? 2'd2 : 2'd0;
          // cached read survives only its own follow-ups
          if (cmd1 != nfc_pkg::CMD_CACHE && cmd1 != nfc_pkg::CMD_STATUS &&
              cmd1 != nfc_pkg::CMD_COL_OUT) s_nxt.read_ok = 1'b0;
          // copy series broken by reset, erase, data load and id commands
          if (cmd1 == nfc_pkg::CMD_RESET || cmd1 == nfc_pkg::CMD_ERASE ||
              cmd1 == nfc_pkg::CMD_DIN || cmd1 == nfc_pkg::CMD_ID)
            s_nxt.copy_ok = 1'b0;
          s_nxt.aidx = s_r.ctrl[nfc_pkg::CTRL_FIRST_LSB +: 2];
          s_nxt.acnt = naddr;
          s_nxt.st = after_bytes(naddr, has2, wt, 1'b0);
        end
      end
      nfc_pkg::ST_ADDR: begin
        if (!s_r.issued) begin
          s_nxt.issued = 1'b1;
          s_nxt.go = 1'b1;
          s_nxt.kind = nfc_pkg::K_ADDR;
          s_nxt.wbyte = s_r.addr[{s_r.aidx, 3'b000} +: 8];
        end else if (e_done) begin
          s_nxt.issued = 1'b0;
          s_nxt.aidx = s_r.aidx + 2'd1;
          s_nxt.acnt = s_r.acnt - 3'd1;
          if (s_r.acnt == 3'd1) begin
            s_nxt.st = after_bytes(naddr, has2, wt, 1'b1);
          end
        end
      end
      nfc_pkg::ST_CMD2: begin
        if (!s_r.issued) begin
          s_nxt.issued = 1'b1;
          s_nxt.go = 1'b1;
          s_nxt.kind = nfc_pkg::K_CMD;
          s_nxt.wbyte = cmd2;
        end else if (e_done) begin
          s_nxt.issued = 1'b0;
          if (cmd1 == nfc_pkg::CMD_READ1 && cmd2 == nfc_pkg::CMD_READ2)
            s_nxt.read_ok = 1'b1;
          if (cmd1 == nfc_pkg::CMD_READ1 && cmd2 == nfc_pkg::CMD_COPY_RD)
            s_nxt.copy_ok = 1'b1;
          if (cmd1 == nfc_pkg::CMD_COPY && cmd2 == nfc_pkg::CMD_PROG)
            s_nxt.copy_ok = 1'b0;
          s_nxt.st = wt ? nfc_pkg::ST_WBUSY : nfc_pkg::ST_ACK;
        end
      end
      nfc_pkg::ST_WBUSY: begin
        s_nxt.wcnt = s_r.wcnt - 4'd1;
        if (s_r.wcnt == 4'd0) s_nxt.st = nfc_pkg::ST_WREADY;
      end
      nfc_pkg::ST_WREADY: begin
        if (busy_indicator) s_nxt.st = nfc_pkg::ST_ACK;
      end
      nfc_pkg::ST_DWR, nfc_pkg::ST_DRD: begin
        if (!s_r.issued) begin
          s_nxt.issued = 1'b1;
          s_nxt.go = 1'b1;
        end else if (e_done) begin
          s_nxt.issued = 1'b0;
          s_nxt.st = nfc_pkg::ST_ACK;
          if (s_r.st == nfc_pkg::ST_DRD) begin
            s_nxt.rdata = {24'h00_0000, e_rbyte};
            s_nxt.rd_idx = s_r.rd_idx + 3'd1;
            if (s_r.rd_mode == 2'd1) s_nxt.sbyte = e_rbyte;
            if (s_r.rd_mode == 2'd2 && s_r.rd_idx == 3'd2)
              s_nxt.id3 = e_rbyte;
          end
        end
      end
      nfc_pkg::ST_ACK: s_nxt.st = nfc_pkg::ST_IDLE;
      default: s_nxt.st = nfc_pkg::ST_IDLE;
    endcase
    s_nxt.wreq = (s_nxt.st != nfc_pkg::ST_ACK);
    s_nxt.wp_n = s_nxt.wp_en || s_nxt.copy_ok;
  end

  // state register
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s_r <= '{st: nfc_pkg::ST_IDLE, ctrl: nfc_pkg::CTRL_RESET,
               wreq: 1'b1, ce_n: 1'b1, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  nfc_pin_cycle u_pin (
    .sys_clk         (sys_clk),
    .resetn          (resetn),
    .go              (s_r.go),
    .kind            (s_r.kind),
    .wbyte           (s_r.wbyte),
    .io_in           (io_in),
    .cle             (cle),
    .ale             (ale),
    .we_n            (we_n),
    .output_strobe_n (output_strobe_n),
    .io_out          (io_out),
    .io_oe           (io_oe),
    .rbyte           (e_rbyte),
    .done            (e_done)
  );

  assign avs_readdata    = s_r.rdata;
  assign avs_waitrequest = s_r.wreq;
  assign ce_n            = s_r.ce_n;
  assign wp_n            = s_r.wp_n;

  // a command sequence starts only if ready or status/reset
  property p_busy_gate;
    @(posedge sys_clk) disable iff (!resetn)
      $rose(s_r.st == nfc_pkg::ST_CMD1) |->
        $past(busy_indicator) || cmd1 == nfc_pkg::CMD_STATUS ||
        cmd1 == nfc_pkg::CMD_RESET;
  endproperty
  a_busy_gate: assert property (p_busy_gate)
    else $error("command started while busy");

  // cache read starts only after a finished normal read
  property p_cache_order;
    @(posedge sys_clk) disable iff (!resetn)
      $rose(s_r.st == nfc_pkg::ST_CMD1) && cmd1 == nfc_pkg::CMD_CACHE
        |-> $past(s_r.read_ok);
  endproperty
  a_cache_order: assert property (p_cache_order)
    else $error("cache read without prior read");

  // write protect released throughout copy series
  property p_copy_wp;
    @(posedge sys_clk) disable iff (!resetn)
      s_r.copy_ok |-> s_r.wp_n;
  endproperty
  a_copy_wp: assert property (p_copy_wp)
    else $error("write protect active during copy");

  // second command follows address or first command directly
  property p_cmd2_direct;
    @(posedge sys_clk) disable iff (!resetn)
      $rose(s_r.st == nfc_pkg::ST_CMD2) |->
        $past(s_r.st == nfc_pkg::ST_ADDR) || $past(s_r.st == nfc_pkg::ST_CMD1);
  endproperty
  a_cmd2_direct: assert property (p_cmd2_direct)
    else $error("second command not direct");

  // wait holds while busy pin is low
  property p_hold_busy;
    @(posedge sys_clk) disable iff (!resetn)
      s_r.st == nfc_pkg::ST_WREADY && !busy_indicator
        |=> s_r.st == nfc_pkg::ST_WREADY;
  endproperty
  a_hold_busy: assert property (p_hold_busy)
    else $error("left busy wait early");

  // completion answered only after ready seen
  property p_ready_done;
    @(posedge sys_clk) disable iff (!resetn)
      s_r.st == nfc_pkg::ST_ACK && $past(s_r.st == nfc_pkg::ST_WREADY)
        |-> $past(busy_indicator) && !s_r.wreq;
  endproperty
  a_ready_done: assert property (p_ready_done)
    else $error("answered before ready");

  // answer lasts exactly one cycle
  property p_ack_pulse;
    @(posedge sys_clk) disable iff (!resetn)
      !s_r.wreq |=> s_r.wreq ##1 (s_r.wreq || s_r.st == nfc_pkg::ST_ACK);
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("waitrequest low too long");
endmodule : nfc_host
`default_nettype wire

// ---- tb/nfc_flash_model.sv ----
// behavioural flash device on the far side of the host byte port
`timescale 1ns/1ps
`default_nettype none
module nfc_flash_model #(
  parameter logic [7:0] MAKER = 8'h5A, // arbitrary value
  parameter logic [7:0] DEVID = 8'hC3, // arbitrary value
  parameter logic [7:0] ID3   = 8'h8E,
  parameter int         BUSY  = 60
) (
  input  wire logic       sys_clk,
  input  wire logic       cle,
  input  wire logic       ale,
  input  wire logic       we_n,
  input  wire logic       output_strobe_n,
  input  wire logic       wp_n,
  input  wire logic [7:0] io_out,
  output logic [7:0]      io_in,
  output logic            busy_indicator
);
  logic [7:0] arr [256];
  logic [7:0] dc  [256];
  logic [7:0] idb [5];
  logic [7:0] col, cmd, dout;
  logic [2:0] ac, idn;
  logic       we_q, re_q;
  int         bc;
  // power-up contents and id bytes
  initial begin
    foreach (arr[i]) arr[i] = 8'h00;
    idb  = '{MAKER, DEVID, ID3, 8'h00, 8'h00};
    bc   = 0;
    we_q = 1'b1;
    re_q = 1'b1;
    col  = 8'h00;
    cmd  = 8'h00;
    dout = 8'h00;
    ac   = 3'h0;
    idn  = 3'h0;
  end
  assign busy_indicator = (bc == 0);
  // released port shows the inverse, never a held value
  assign io_in = output_strobe_n ? ~dout : dout;
  // strobe edges seen at the clock, all host pins are registers
  always @(posedge sys_clk) begin
    we_q <= we_n;
    re_q <= output_strobe_n;
    if (bc > 0) bc <= bc - 1;
    if (!we_q && we_n && cle) begin
      cmd <= io_out;
      ac  <= 3'h0;
      idn <= 3'h0;
      case (io_out)
        8'h30, 8'h31, 8'h3F, 8'h3A: begin
          bc <= BUSY;
          dc <= arr;
        end
        8'h10, 8'h15: begin
          bc <= BUSY;
          if (wp_n) arr <= dc;
        end
        8'hD0: begin
          bc <= 2 * BUSY;
          if (wp_n) foreach (arr[i]) arr[i] <= 8'hFF;
        end
        default: ;
      endcase
    end else if (!we_q && we_n && ale) begin
      if (ac == 3'h0) col <= io_out;
      ac <= ac + 3'h1;
    end else if (!we_q && we_n) begin
      dc[col] <= io_out;
      col     <= col + 8'h01;
    end
    if (re_q && !output_strobe_n) begin
      dout <= cmd == 8'h70 ? {wp_n, bc == 0, bc == 0, 5'h00}
            : cmd == 8'h90 ? idb[idn] : dc[col];
      col  <= col + 8'h01;
      idn  <= idn + 3'h1;
    end
  end
endmodule : nfc_flash_model
`default_nettype wire

// ---- tb/tb_nfc_host.sv ----
// self-checking bench for the flash host sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_nfc_host;
  logic        sys_clk = 1'b0;
  logic        resetn  = 1'b0;
  logic [2:0]  adr     = 3'h0;
  logic        rd      = 1'b0;
  logic        wr      = 1'b0;
  logic [31:0] wd      = 32'h0000_0000;
  logic [31:0] rdat, q;
  logic        wq, ce_n, cle, ale, we_n, rs_n, wp_n, oe, busy;
  logic [7:0]  io_out, io_in;
  int          mismatches  = 0;
  int          checks_done = 0;
  nfc_host nfc_host_i (.sys_clk(sys_clk), .resetn(resetn),
    .avs_address(adr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wd), .avs_readdata(rdat), .avs_waitrequest(wq),
    .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n),
    .output_strobe_n(rs_n), .wp_n(wp_n), .io_out(io_out), .io_oe(oe),
    .io_in(io_in), .busy_indicator(busy));
  nfc_flash_model nfc_flash_model_i (.sys_clk(sys_clk), .cle(cle),
    .ale(ale), .we_n(we_n), .output_strobe_n(rs_n), .wp_n(wp_n),
    .io_out(io_out), .io_in(io_in), .busy_indicator(busy));
  initial forever #5 sys_clk = ~sys_clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // one Avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [2:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    adr <= a;
    wd  <= d;
    wr  <= w;
    rd  <= ~w;
    do begin
      @(posedge sys_clk);
      n++;
    end while (wq !== 1'b0 && n < 5000);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
    if (n >= 5000) mismatches++;
  endtask : bus
  task automatic cmd(input logic [7:0] c1, input logic [7:0] c2,
                     input logic [2:0] na, input logic w,
                     input logic [1:0] f);
    bus(1'b1, 3'h0, {9'h000, f, w, c2 != 8'h00, na, c2, c1});
  endtask : cmd
  task automatic dw(input logic [7:0] b);
    bus(1'b1, 3'h2, {24'h00_0000, b});
  endtask : dw
  task automatic t_id;
    bus(1'b1, 3'h1, 32'h0000_0000);
    cmd(8'h90, 8'h00, 3'h1, 1'b0, 2'h0);
    bus(1'b0, 3'h2, 32'h0000_0000);
    chk(q[7:0], 8'h5A);
    bus(1'b0, 3'h2, 32'h0000_0000);
    chk(q[7:0], 8'hC3);
    bus(1'b0, 3'h2, 32'h0000_0000);
    chk(q[7:0], 8'h8E);
    bus(1'b0, 3'h3, 32'h0000_0000);
    chk(q[11:8], 4'hE);
  endtask : t_id
  // load, two column changes, confirm, status, read back
  task automatic t_prog;
    bus(1'b1, 3'h4, 32'h0000_0001);
    bus(1'b1, 3'h1, 32'h0000_0000);
    cmd(8'h80, 8'h00, 3'h4, 1'b0, 2'h0);
    dw(8'hA1);
    dw(8'hB2);
    bus(1'b1, 3'h1, 32'h0000_0010);
    cmd(8'h85, 8'h00, 3'h2, 1'b0, 2'h0);
    dw(8'hC3);
    bus(1'b1, 3'h1, 32'h0000_0020);
    cmd(8'h85, 8'h00, 3'h2, 1'b0, 2'h0);
    dw(8'hD4);
    cmd(8'h10, 8'h00, 3'h0, 1'b1, 2'h0);
    chk(busy, 1'b1);
    cmd(8'h70, 8'h00, 3'h0, 1'b0, 2'h0);
    bus(1'b0, 3'h2, 32'h0000_0000);
    chk(q[7:0], 8'hE0);
    bus(1'b0, 3'h3, 32'h0000_0000);
    chk(q[6:3], 4'hA);
    bus(1'b1, 3'h1, 32'h0000_0000);
    cmd(8'h00, 8'h30, 3'h4, 1'b1, 2'h0);
    bus(1'b0, 3'h2, 32'h0000_0000);
    chk(q[7:0], 8'hA1);
    bus(1'b0, 3'h2, 32'h0000_0000);
    chk(q[7:0], 8'hB2);
    bus(1'b1, 3'h1, 32'h0000_0020);
    cmd(8'h05, 8'hE0, 3'h2, 1'b0, 2'h0);
    bus(1'b0, 3'h2, 32'h0000_0000);
    chk(q[7:0], 8'hD4);
  endtask : t_prog
  // erase, refusal while busy, status allowed, erased data
  task automatic t_erase;
    int n;
    n = 0;
    cmd(8'h60, 8'hD0, 3'h2, 1'b0, 2'h2);
    chk(busy, 1'b0);
    cmd(8'h80, 8'h00, 3'h4, 1'b0, 2'h0);
    bus(1'b0, 3'h3, 32'h0000_0000);
    chk(q[2:1], 2'h2);
    cmd(8'h70, 8'h00, 3'h0, 1'b0, 2'h0);
    bus(1'b0, 3'h3, 32'h0000_0000);
    chk(q[2], 1'b0);
    while (busy !== 1'b1 && n < 1000) begin
      @(posedge sys_clk);
      n++;
    end
    chk(n > 60, 1'b1);
    cmd(8'h00, 8'h30, 3'h4, 1'b1, 2'h0);
    bus(1'b0, 3'h2, 32'h0000_0000);
    chk(q[7:0], 8'hFF);
  endtask : t_erase
  task automatic t_cache;
    cmd(8'h90, 8'h00, 3'h1, 1'b0, 2'h0);
    cmd(8'h31, 8'h00, 3'h0, 1'b1, 2'h0);
    bus(1'b0, 3'h3, 32'h0000_0000);
    chk(q[2], 1'b1);
    cmd(8'h00, 8'h30, 3'h4, 1'b1, 2'h0);
    cmd(8'h31, 8'h00, 3'h0, 1'b1, 2'h0);
    bus(1'b0, 3'h3, 32'h0000_0000);
    chk({q[12], q[2]}, 2'h2);
    bus(1'b0, 3'h2, 32'h0000_0000);
    chk(q[7:0], 8'hFF);
    cmd(8'h3F, 8'h00, 3'h0, 1'b1, 2'h0);
    cmd(8'h31, 8'h00, 3'h0, 1'b1, 2'h0);
    bus(1'b0, 3'h3, 32'h0000_0000);
    chk({q[12], q[2]}, 2'h1);
  endtask : t_cache
  task automatic t_prot;
    bus(1'b1, 3'h4, 32'h0000_0000);
    chk(wp_n, 1'b0);
    cmd(8'h80, 8'h00, 3'h4, 1'b0, 2'h0);
    dw(8'h55);
    cmd(8'h10, 8'h00, 3'h0, 1'b1, 2'h0);
    cmd(8'h70, 8'h00, 3'h0, 1'b0, 2'h0);
    bus(1'b0, 3'h2, 32'h0000_0000);
    chk(q[7:0], 8'h60);
    cmd(8'h00, 8'h30, 3'h4, 1'b1, 2'h0);
    bus(1'b0, 3'h2, 32'h0000_0000);
    chk(q[7:0], 8'hFF);
  endtask : t_prot
  // copy refused first, then read, cached copy, plain confirm
  task automatic t_copy;
    cmd(8'h8C, 8'h10, 3'h4, 1'b1, 2'h0);
    bus(1'b0, 3'h3, 32'h0000_0000);
    chk(q[2], 1'b1);
    bus(1'b1, 3'h1, 32'h0000_0000);
    cmd(8'h00, 8'h3A, 3'h4, 1'b1, 2'h0);
    bus(1'b0, 3'h3, 32'h0000_0000);
    chk({q[13], q[2]}, 2'h2);
    chk(wp_n, 1'b1);
    bus(1'b0, 3'h2, 32'h0000_0000);
    chk(q[7:0], 8'hFF);
    cmd(8'h8C, 8'h15, 3'h4, 1'b1, 2'h0);
    bus(1'b0, 3'h3, 32'h0000_0000);
    chk({q[13], q[2]}, 2'h2);
    cmd(8'h8C, 8'h10, 3'h4, 1'b1, 2'h0);
    bus(1'b0, 3'h3, 32'h0000_0000);
    chk({q[13], q[2]}, 2'h0);
    chk(wp_n, 1'b0);
  endtask : t_copy
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : wrap_up
  initial begin
    #500_000;
    mismatches++;
    wrap_up;
  end
  initial begin
    repeat (20) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (2) @(posedge sys_clk);
    chk({ce_n, wp_n, oe, wq}, 4'h1);
    t_id;
    t_prog;
    t_erase;
    t_cache;
    t_prot;
    t_copy;
    wrap_up;
  end
endmodule : tb_nfc_host
`default_nettype wire
